/* File: hw/spf_port.sv */
// Behaviour
// - Transmit machine starts idle after reset, stays until transmit control written.
// - Transmit control write while idle arms the transmit machine.
// - Armed machine waits for a data write; the first one makes it active.
// - Each transmit data write while loading lowers the remaining count by four, stopping at zero.
// - Count at zero returns transmit machine idle, raising tx event if enabled.
// - Receive machine idles until a data read, which makes it active.
// - Each receive data read while unloading lowers receive remaining count by four.
// - Receive machine stays active until remaining count is zero, then idles.
// - Transmit and receive FIFO words use the logical-layer port beat format; the length FIFO holds 9-bit byte counts.
// - Both polling and interrupt operation work in each direction.
// - Receive activity is event two, transmit completion is event three.
// - A packet fully received into the receive FIFO flags an event.
//
// Our own choices: the plain strobed port and the address map.
module spf_port #(
  parameter int TX_DEPTH  = 128,
  parameter int RX_DEPTH  = 128,
  parameter int LEN_DEPTH = 8
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic [spf_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [spf_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [spf_pkg::DATA_W-1:0] o_rdata,
  output spf_pkg::spf_beat_type           o_tx_beat,
  output logic                            o_tx_valid,
  input  wire logic                       i_tx_ready,
  input  wire spf_pkg::spf_beat_type      i_rx_beat,
  input  wire logic                       i_rx_valid,
  output logic                            o_rx_ready,
  output logic                            o_tx_event,
  output logic                            o_rx_event,
  output logic                            o_irq
);

  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int LCW = $clog2(LEN_DEPTH + 1);
  localparam int BW  = $bits(spf_pkg::spf_beat_type);

  // Register access decode.
  logic                      wr_tx_control;
  logic                      wr_tx_data;
  logic                      wr_rx_control;
  logic                      wr_evt_status;
  logic                      wr_evt_mask;
  logic                      rd_rx_data;
  assign wr_tx_control = i_wr && (i_addr == spf_pkg::OFS_TX_CONTROL);
  assign wr_tx_data    = i_wr && (i_addr == spf_pkg::OFS_TX_DATA);
  assign wr_rx_control = i_wr && (i_addr == spf_pkg::OFS_RX_CONTROL);
  assign wr_evt_status = i_wr && (i_addr == spf_pkg::OFS_EVT_STATUS);
  assign wr_evt_mask   = i_wr && (i_addr == spf_pkg::OFS_EVT_MASK);
  assign rd_rx_data    = i_rd && (i_addr == spf_pkg::OFS_RX_DATA);

  // Software-visible control registers.
  logic [31:0]               tx_control;
  logic [31:0]               rx_control;
  logic [31:0]               evt_status;
  logic [31:0]               evt_mask;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_control <= spf_pkg::TX_CONTROL_RST;
      rx_control <= spf_pkg::RX_CONTROL_RST;
      evt_mask   <= spf_pkg::EVT_MASK_RST;
    end else begin
      if (wr_tx_control) begin
        tx_control <= i_wdata;
      end
      if (wr_rx_control) begin
        rx_control <= i_wdata;
      end
      if (wr_evt_mask) begin
        evt_mask <= i_wdata;
      end
    end
  end

  // Transmit side: loading state machine and its FIFO.
  spf_pkg::spf_tx_state_type tx_state;
  spf_pkg::spf_tx_state_type next_tx_state;
  logic [8:0]                tx_remaining;
  logic [8:0]                next_tx_remaining;
  logic                      tx_done;
  logic                      tx_push;
  spf_pkg::spf_beat_type     tx_push_beat;
  logic                      tx_push_ready;
  logic                      tx_pop_valid;
  logic                      tx_pop_ready;
  logic [BW-1:0]             tx_pop_data;
  logic [TCW-1:0]            tx_count;
  logic                      tx_ready;
  always_comb begin
    next_tx_state     = tx_state;
    next_tx_remaining = tx_remaining;
    tx_push           = 1'b0;
    tx_done           = 1'b0;
    tx_push_beat      = '0;
    case (tx_state)
      spf_pkg::TX_IDLE: begin
        if (wr_tx_control) begin
          next_tx_state     = spf_pkg::TX_ARMED;
          next_tx_remaining = i_wdata[spf_pkg::LEN_LSB +: spf_pkg::LEN_W];
        end
      end
      spf_pkg::TX_ARMED: begin
        if (wr_tx_data) begin
          next_tx_state     = spf_pkg::TX_ACTIVE;
          next_tx_remaining = spf_pkg::spf_sat_sub(tx_remaining);
          tx_push           = 1'b1;
          tx_push_beat.sof  = 1'b1;
        end
      end
      spf_pkg::TX_ACTIVE: begin
        if (tx_remaining == 9'h000) begin
          next_tx_state = spf_pkg::TX_IDLE;
          tx_done       = 1'b1;
        end else if (wr_tx_data) begin
          next_tx_remaining = spf_pkg::spf_sat_sub(tx_remaining);
          tx_push           = 1'b1;
        end
      end
      default: begin
        next_tx_state = spf_pkg::TX_IDLE;
      end
    endcase
    // The word that brings the count to zero closes the packet.
    tx_push_beat.eof  = (next_tx_remaining == 9'h000);
    tx_push_beat.data = i_wdata;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_state     <= spf_pkg::TX_IDLE;
      tx_remaining <= 9'h000;
    end else begin
      tx_state     <= next_tx_state;
      tx_remaining <= next_tx_remaining;
    end
  end

  spf_fifo #(
    .WIDTH (BW),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_push_valid (tx_push),
    .o_push_ready (tx_push_ready),
    .i_push_data  (tx_push_beat),
    .o_pop_valid  (tx_pop_valid),
    .i_pop_ready  (tx_pop_ready),
    .o_pop_data   (tx_pop_data),
    .o_count      (tx_count)
  );

  // Room for a whole packet is only reported in the ready flag; nothing guards the push.
  assign tx_ready     = (tx_state == spf_pkg::TX_IDLE) &&
                        (TX_DEPTH - int'(tx_count) >= spf_pkg::MAX_PKT_WORDS);
  assign tx_pop_ready = !o_tx_valid || i_tx_ready;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_beat  <= '0;
    end else if (tx_pop_ready) begin
      o_tx_valid <= tx_pop_valid;
      o_tx_beat  <= tx_pop_data;
    end
  end

  // Receive side: incoming packets, their lengths, and the unloading machine.
  logic                      rx_accept;
  logic [8:0]                rx_len_acc;
  logic [8:0]                rx_len_total;
  logic                      rx_data_ready;
  logic                      rx_pop;
  logic                      rx_pop_valid;
  logic [BW-1:0]             rx_pop_data;
  logic [RCW-1:0]            rx_count;
  logic                      len_ready;
  logic                      len_pop;
  logic                      len_valid;
  logic [8:0]                len_head;
  logic [LCW-1:0]            len_count;
  logic                      rx_done;
  spf_pkg::spf_beat_type     rx_head;
  assign rx_accept    = i_rx_valid && o_rx_ready;
  assign rx_len_total = (rx_len_acc > 9'(spf_pkg::MAX_PKT_BYTES)) ?
                        9'(spf_pkg::MAX_PKT_BYTES) : rx_len_acc;
  assign rx_head      = rx_pop_data;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_len_acc <= spf_pkg::BYTES_PER_WORD;
    end else if (rx_accept) begin
      if (i_rx_beat.eof) begin
        rx_len_acc <= spf_pkg::BYTES_PER_WORD;
      end else if (rx_len_acc < 9'(spf_pkg::MAX_PKT_BYTES)) begin
        rx_len_acc <= 9'(rx_len_acc + spf_pkg::BYTES_PER_WORD);
      end
    end
  end

  spf_fifo #(
    .WIDTH (BW),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_push_valid (rx_accept),
    .o_push_ready (rx_data_ready),
    .i_push_data  (i_rx_beat),
    .o_pop_valid  (rx_pop_valid),
    .i_pop_ready  (rx_pop),
    .o_pop_data   (rx_pop_data),
    .o_count      (rx_count)
  );

  spf_fifo #(
    .WIDTH (9),
    .DEPTH (LEN_DEPTH)
  ) u_len_fifo (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_push_valid (rx_accept && i_rx_beat.eof),
    .o_push_ready (len_ready),
    .i_push_data  (rx_len_total),
    .o_pop_valid  (len_valid),
    .i_pop_ready  (len_pop),
    .o_pop_data   (len_head),
    .o_count      (len_count)
  );

  // Ready is registered, so it is raised only when both FIFOs had two or more free slots the cycle before.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_ready <= 1'b0;
    end else begin
      o_rx_ready <= rx_data_ready && len_ready &&
                    (int'(rx_count) <= RX_DEPTH - 2) &&
                    (int'(len_count) <= LEN_DEPTH - 2);
    end
  end
  spf_pkg::spf_rx_state_type rx_state;
  spf_pkg::spf_rx_state_type next_rx_state;
  logic [8:0]                rx_remaining;
  logic [8:0]                next_rx_remaining;
  always_comb begin
    next_rx_state     = rx_state;
    next_rx_remaining = rx_remaining;
    len_pop           = 1'b0;
    rx_done           = 1'b0;
    case (rx_state)
      spf_pkg::RX_IDLE: begin
        if (rd_rx_data) begin
          next_rx_state     = spf_pkg::RX_ACTIVE;
          len_pop           = len_valid;
          next_rx_remaining = len_valid ? spf_pkg::spf_sat_sub(len_head) : 9'h000;
        end
      end
      spf_pkg::RX_ACTIVE: begin
        if (rx_remaining == 9'h000) begin
          next_rx_state = spf_pkg::RX_IDLE;
          rx_done       = 1'b1;
        end else if (rd_rx_data) begin
          next_rx_remaining = spf_pkg::spf_sat_sub(rx_remaining);
        end
      end
      default: begin
        next_rx_state = spf_pkg::RX_IDLE;
      end
    endcase
  end

  // A word leaves the FIFO for every counted read of the data register.
  assign rx_pop = rd_rx_data && rx_pop_valid &&
                  ((rx_state == spf_pkg::RX_IDLE) ? len_valid : (rx_remaining != 9'h000));
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_state     <= spf_pkg::RX_IDLE;
      rx_remaining <= 9'h000;
    end else begin
      rx_state     <= next_rx_state;
      rx_remaining <= next_rx_remaining;
    end
  end

  // Events: sticky status with write-one-to-clear; a new event beats the clear.
  logic [31:0]               evt_set;
  always_comb begin
    evt_set                      = '0;
    evt_set[spf_pkg::EVT_RX_BIT] = rx_accept && i_rx_beat.eof &&
                                   rx_control[spf_pkg::RX_EVT_EN_BIT];
    evt_set[spf_pkg::EVT_TX_BIT] = tx_done && tx_control[spf_pkg::TX_EVT_EN_BIT];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_status <= '0;
    end else if (wr_evt_status) begin
      evt_status <= (evt_status & ~i_wdata) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_event <= 1'b0;
      o_rx_event <= 1'b0;
      o_irq      <= 1'b0;
    end else begin
      o_tx_event <= evt_set[spf_pkg::EVT_TX_BIT];
      o_rx_event <= evt_set[spf_pkg::EVT_RX_BIT];
      o_irq      <= |(evt_status & evt_mask);
    end
  end

  // Read data, valid in the cycle after the read strobe.
  logic [31:0]               tx_status_word;
  logic [31:0]               rx_status_word;
  logic [31:0]               next_rdata;
  always_comb begin
    tx_status_word                                           = '0;
    tx_status_word[spf_pkg::LEN_LSB +: spf_pkg::LEN_W]       = tx_remaining;
    tx_status_word[spf_pkg::TX_READY_BIT]                    = tx_ready;
    tx_status_word[spf_pkg::TX_ARMED_BIT]                    = (tx_state == spf_pkg::TX_ARMED);
    tx_status_word[spf_pkg::TX_ACTIVE_BIT]                   = (tx_state == spf_pkg::TX_ACTIVE);
    rx_status_word                                           = '0;
    rx_status_word[spf_pkg::LEN_LSB +: spf_pkg::LEN_W]       = rx_remaining;
    rx_status_word[spf_pkg::RX_AVAIL_BIT]                    = len_valid;
    rx_status_word[spf_pkg::RX_ACTIVE_BIT]                   = (rx_state == spf_pkg::RX_ACTIVE);
    rx_status_word[spf_pkg::RX_PKTS_LSB +: 8]                = 8'(len_count);
  end

  always_comb begin
    next_rdata = '0;
    case (i_addr)
      spf_pkg::OFS_TX_CONTROL: next_rdata = tx_control;
      spf_pkg::OFS_TX_STATUS:  next_rdata = tx_status_word;
      spf_pkg::OFS_RX_CONTROL: next_rdata = rx_control;
      spf_pkg::OFS_RX_STATUS:  next_rdata = rx_status_word;
      spf_pkg::OFS_RX_DATA:    next_rdata = rx_pop ? rx_head.data : 32'h0000_0000;
      spf_pkg::OFS_EVT_STATUS: next_rdata = evt_status;
      spf_pkg::OFS_EVT_MASK:   next_rdata = evt_mask;
      default:                 next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? next_rdata : '0;
    end
  end

endmodule : spf_port

/* File: hw/spf_pkg.sv */
package spf_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          LEN_W           = 9;

  localparam logic [7:0]  OFS_TX_CONTROL  = 8'h00;
  localparam logic [7:0]  OFS_TX_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_TX_DATA     = 8'h08;
  localparam logic [7:0]  OFS_RX_CONTROL  = 8'h0C;
  localparam logic [7:0]  OFS_RX_STATUS   = 8'h10;
  localparam logic [7:0]  OFS_RX_DATA     = 8'h14;
  localparam logic [7:0]  OFS_EVT_STATUS  = 8'h18;
  localparam logic [7:0]  OFS_EVT_MASK    = 8'h1C;

  // Field positions.
  localparam int          LEN_LSB         = 0;
  localparam int          TX_EVT_EN_BIT   = 16;
  localparam int          RX_EVT_EN_BIT   = 0;
  localparam int          TX_READY_BIT    = 16;
  localparam int          TX_ARMED_BIT    = 17;
  localparam int          TX_ACTIVE_BIT   = 18;
  localparam int          RX_AVAIL_BIT    = 16;
  localparam int          RX_ACTIVE_BIT   = 17;
  localparam int          RX_PKTS_LSB     = 24;
  localparam int          EVT_RX_BIT      = 2;
  localparam int          EVT_TX_BIT      = 3;

  // Reset values.
  localparam logic [31:0] TX_CONTROL_RST  = 32'h0000_0000;
  localparam logic [31:0] RX_CONTROL_RST  = 32'h0000_0001;
  localparam logic [31:0] EVT_MASK_RST    = 32'h0000_0000;

  // Byte counts.
  localparam logic [8:0]  BYTES_PER_WORD  = 9'h004;
  localparam int          MAX_PKT_BYTES   = 276;
  localparam int          MAX_PKT_WORDS   = (MAX_PKT_BYTES + 3) / 4;

  // One beat of the logical-layer port format.
  typedef struct packed {
    logic        sof;
    logic        eof;
    logic [31:0] data;
  } spf_beat_type;

  typedef enum {TX_IDLE, TX_ARMED, TX_ACTIVE} spf_tx_state_type;
  typedef enum {RX_IDLE, RX_ACTIVE} spf_rx_state_type;

  // Lowers a byte count by one word and stops at zero.
  function automatic logic [8:0] spf_sat_sub(input logic [8:0] value);
    spf_sat_sub = (value > BYTES_PER_WORD) ? 9'(value - BYTES_PER_WORD) : 9'h000;
  endfunction : spf_sat_sub

endpackage : spf_pkg

/* File: hw/spf_fifo.sv */
module spf_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 128
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_push_valid,
  output logic                            o_push_ready,
  input  wire logic [WIDTH-1:0]           i_push_data,
  output logic                            o_pop_valid,
  input  wire logic                       i_pop_ready,
  output logic [WIDTH-1:0]                o_pop_data,
  output logic [$clog2(DEPTH+1)-1:0]      o_count
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             do_push;
  logic             do_pop;

  assign o_push_ready = (count != CW'(DEPTH));
  assign o_pop_valid  = (count != '0);
  assign o_pop_data   = mem[rd_ptr];
  assign o_count      = count;
  assign do_push      = i_push_valid && o_push_ready;
  assign do_pop       = i_pop_ready && o_pop_valid;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] ptr);
    bump = (ptr == AW'(DEPTH - 1)) ? '0 : AW'(ptr + 1'b1);
  endfunction : bump

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= i_push_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (do_push && !do_pop) begin
        count <= CW'(count + 1'b1);
      end else if (do_pop && !do_push) begin
        count <= CW'(count - 1'b1);
      end
    end
  end

endmodule : spf_fifo

/* File: verification/spf_port_checker.sv */
module spf_port_checker (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic [spf_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [spf_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  input  wire logic [spf_pkg::DATA_W-1:0] o_rdata,
  input  wire spf_pkg::spf_beat_type      o_tx_beat,
  input  wire logic                       o_tx_valid,
  input  wire logic                       i_tx_ready,
  input  wire spf_pkg::spf_beat_type      i_rx_beat,
  input  wire logic                       i_rx_valid,
  input  wire logic                       o_rx_ready,
  input  wire logic                       o_tx_event,
  input  wire logic                       o_rx_event,
  input  wire logic                       o_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  logic tx_wr;
  logic rx_eof;
  logic rd_txs;
  logic rd_rxs;
  logic cause;

  assign tx_wr  = i_wr && (i_addr == spf_pkg::OFS_TX_DATA);
  assign rx_eof = i_rx_valid && o_rx_ready && i_rx_beat.eof;
  assign rd_txs = i_rd && (i_addr == spf_pkg::OFS_TX_STATUS);
  assign rd_rxs = i_rd && (i_addr == spf_pkg::OFS_RX_STATUS);
  assign cause  = o_tx_event || o_rx_event || i_wr;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  tx_event_pulse_a: assert property (o_tx_event |=> !o_tx_event)
    else $error("tx event longer than one cycle");
  tx_event_cause_a: assert property (o_tx_event |-> $past(tx_wr, 2) || $past(tx_wr, 3))
    else $error("tx event without a final data write");
  rx_event_pulse_a: assert property (o_rx_event |=> !o_rx_event)
    else $error("rx event longer than one cycle");
  rx_event_cause_a: assert property (o_rx_event |-> $past(rx_eof, 1) || $past(rx_eof, 2))
    else $error("rx event without an end beat");
  irq_rise_a: assert property ($rose(o_irq) |-> $past(cause, 1) || $past(cause, 2))
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(i_wr, 1) || $past(i_wr, 2))
    else $error("interrupt fell without a write");
  tx_beat_hold_a: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_beat))
    else $error("tx beat dropped while stalled");
  tx_ready_state_a: assert property ($past(rd_txs) |->
    !(o_rdata[spf_pkg::TX_READY_BIT] && (o_rdata[spf_pkg::TX_ARMED_BIT]
    || o_rdata[spf_pkg::TX_ACTIVE_BIT])))
    else $error("tx ready shown while busy");
  rx_count_active_a: assert property ($past(rd_rxs) && (o_rdata[8:0] != 9'h000) |->
    o_rdata[spf_pkg::RX_ACTIVE_BIT])
    else $error("rx count left while idle");

  cover property (o_tx_event);
  cover property (o_rx_event);
  cover property ($rose(o_irq));
endmodule : spf_port_checker

/* File: verification/spf_port_tb_top.sv */
module spf_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  i_clk;
  logic                  i_rst;
  logic                  i_wr;
  logic                  i_rd;
  logic                  i_tx_ready;
  logic                  i_rx_valid;
  logic                  o_tx_valid;
  logic                  o_rx_ready;
  logic                  o_tx_event;
  logic                  o_rx_event;
  logic                  o_irq;
  logic [7:0]            i_addr;
  logic [31:0]           i_wdata;
  logic [31:0]           o_rdata;
  logic [31:0]           rd_val;
  spf_pkg::spf_beat_type o_tx_beat;
  spf_pkg::spf_beat_type i_rx_beat;
  spf_pkg::spf_beat_type beats[$];
  int                    n_mismatch = 0;
  int                    tests_run = 0;
  int                    n_tx_evt = 0;
  int                    n_rx_evt = 0;
  int                    cycles = 0;

  spf_port spf_port_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tx_beat(o_tx_beat),
    .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .i_rx_beat(i_rx_beat),
    .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready), .o_tx_event(o_tx_event),
    .o_rx_event(o_rx_event), .o_irq(o_irq));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Event pulses are counted and delivered beats collected for later comparison.
  always @(posedge i_clk) begin
    cycles++;
    if (o_tx_event === 1'b1) n_tx_evt++;
    if (o_rx_event === 1'b1) n_rx_evt++;
    if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) beats.push_back(o_tx_beat);
    if (cycles == 5000) begin
      $display("mismatch at %0t: timeout", $time);
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string what);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 rd_val = o_rdata;
    chk(rd_val & m, e, what);
  endtask : rchk

  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_tx_ready = 1'b0;
    i_rx_valid = 1'b0;
    i_rx_beat = '0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    rchk(spf_pkg::OFS_TX_STATUS, 32'hFFFF_FFFF, 32'h0001_0000, "tx status at reset");
    rchk(spf_pkg::OFS_RX_CONTROL, 32'hFFFF_FFFF, 32'h0000_0001, "rx control at reset");
    rchk(spf_pkg::OFS_EVT_MASK, 32'hFFFF_FFFF, 32'h0000_0000, "mask at reset");
    wr(spf_pkg::OFS_TX_DATA, 32'hDEAD_0000);
    rchk(spf_pkg::OFS_TX_STATUS, 32'hFFFF_FFFF, 32'h0001_0000, "data write in idle");
    wr(spf_pkg::OFS_EVT_MASK, 32'h0000_0008);
    wr(spf_pkg::OFS_TX_CONTROL, 32'h0001_0006);
    rchk(spf_pkg::OFS_TX_STATUS, 32'hFFFF_FFFF, 32'h0002_0006, "armed with length");
    wr(spf_pkg::OFS_TX_DATA, 32'h1111_1111);
    rchk(spf_pkg::OFS_TX_STATUS, 32'hFFFF_FFFF, 32'h0004_0002, "active after word");
    wr(spf_pkg::OFS_TX_DATA, 32'h2222_2222);
    repeat (2) @(posedge i_clk);
    rchk(spf_pkg::OFS_TX_STATUS, 32'hFFFF_FFFF, 32'h0001_0000, "partial word ends");
    chk(32'(n_tx_evt), 32'h1, "tx event count");
    chk(32'(o_irq), 32'h1, "irq after tx event");
    rchk(spf_pkg::OFS_EVT_STATUS, 32'h0000_000C, 32'h0000_0008, "tx event bit");
    chk(32'(o_tx_valid), 32'h1, "beat held while stalled");
    chk(o_tx_beat.data, 32'h1111_1111, "held beat data");
    @(posedge i_clk);
    i_tx_ready <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk(32'(beats.size()), 32'h2, "beats delivered");
    chk({30'h0, beats[0].sof, beats[0].eof}, 32'h0000_0002, "beat 0 marks");
    chk(beats[0].data, 32'h1111_1111, "beat 0 data");
    chk({30'h0, beats[1].sof, beats[1].eof}, 32'h0000_0001, "beat 1 marks");
    chk(beats[1].data, 32'h2222_2222, "beat 1 data");
    wr(spf_pkg::OFS_EVT_STATUS, 32'h0000_0008);
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h0, "irq after clear");
    wr(spf_pkg::OFS_TX_CONTROL, 32'h0000_0004);
    wr(spf_pkg::OFS_TX_DATA, 32'h3333_3333);
    repeat (3) @(posedge i_clk);
    chk(32'(n_tx_evt), 32'h1, "event disabled");
    chk(32'(o_rx_ready), 32'h1, "rx ready idle");
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      i_rx_valid <= 1'b1;
      i_rx_beat  <= {k == 0, k == 2, 32'h0000_00A0 + 32'(k)};
    end
    @(posedge i_clk);
    i_rx_valid <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk(32'(n_rx_evt), 32'h1, "rx event count");
    chk(32'(o_irq), 32'h0, "masked rx event");
    rchk(spf_pkg::OFS_RX_STATUS, 32'hFF01_0000, 32'h0101_0000, "packet waiting");
    rchk(spf_pkg::OFS_EVT_STATUS, 32'h0000_000C, 32'h0000_0004, "rx event bit");
    wr(spf_pkg::OFS_EVT_MASK, 32'h0000_000C);
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h1, "irq after unmask");
    wr(spf_pkg::OFS_EVT_STATUS, 32'h0000_0004);
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h0, "irq after rx clear");
    rchk(spf_pkg::OFS_RX_DATA, 32'hFFFF_FFFF, 32'h0000_00A0, "rx word 0");
    rchk(spf_pkg::OFS_RX_STATUS, 32'h0002_01FF, 32'h0002_0008, "rx count 8");
    rchk(spf_pkg::OFS_RX_DATA, 32'hFFFF_FFFF, 32'h0000_00A1, "rx word 1");
    rchk(spf_pkg::OFS_RX_STATUS, 32'h0002_01FF, 32'h0002_0004, "rx count 4");
    rchk(spf_pkg::OFS_RX_DATA, 32'hFFFF_FFFF, 32'h0000_00A2, "rx word 2");
    rchk(spf_pkg::OFS_RX_STATUS, 32'h0002_01FF, 32'h0000_0000, "rx back idle");
    rchk(spf_pkg::OFS_RX_DATA, 32'hFFFF_FFFF, 32'h0000_0000, "empty rx read");
    rchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    wr(spf_pkg::OFS_RX_CONTROL, 32'h0000_0000);
    @(posedge i_clk);
    i_rx_valid <= 1'b1;
    i_rx_beat  <= {2'b11, 32'h0000_00B0};
    @(posedge i_clk);
    i_rx_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk(32'(n_rx_evt), 32'h1, "rx event disabled");
    rchk(spf_pkg::OFS_RX_STATUS, 32'hFF01_0000, 32'h0101_0000, "packet held");
    rchk(spf_pkg::OFS_EVT_STATUS, 32'h0000_000C, 32'h0000_0000, "no rx event bit");
    test_done();
  end
endmodule : spf_port_tb_top

bind spf_port spf_port_checker spf_port_checker_i (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_tx_beat(o_tx_beat), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
  .i_rx_beat(i_rx_beat), .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready),
  .o_tx_event(o_tx_event), .o_rx_event(o_rx_event), .o_irq(o_irq));
